/* verilog/stw_pkg.sv */
// stw_pkg: register offsets, field positions, reset values and divide codes
// for the timing and window register group of the sensor control bank.
// assumes: 8-bit register addresses and 8-bit register data.
`default_nettype none
package stw_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // bank select
  localparam logic [7:0] STW_OFF_BANK_SEL = 8'hFF;
  localparam logic [7:0] STW_BANK_DEVICE = 8'h01;
  localparam logic [7:0] STW_RST_BANK_SEL = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] STW_OFF_HSYNC_END_LOW = 8'h31;
  localparam logic [7:0] STW_OFF_PCLK_HWIN_LOW = 8'h32;
  localparam logic [7:0] STW_OFF_ZOOM_HCTRL = 8'h34;
  localparam logic [7:0] STW_OFF_GAIN_EXP_HIGH = 8'h45;
  localparam logic [7:0] STW_OFF_FLEN_PAD_LOW = 8'h46;
  localparam logic [7:0] STW_OFF_FLEN_PAD_HIGH = 8'h47;
  localparam logic [7:0] STW_OFF_ZOOM_VST_LOW = 8'h48;
  localparam logic [7:0] STW_OFF_ZOOM_VST_HIGH = 8'h49;
  localparam logic [7:0] STW_OFF_FLASH_CTRL = 8'h4B;
  localparam logic [7:0] STW_OFF_BAND_STEP_HIGH = 8'h4E;
  localparam logic [7:0] STW_OFF_BAND_50_LOW = 8'h4F;
  localparam logic [7:0] STW_OFF_BAND_60_LOW = 8'h50;
  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] STW_RST_HSYNC_END_LOW = 8'h30;
  localparam logic [7:0] STW_RST_PCLK_HWIN_LOW = 8'h36;
  localparam logic [7:0] STW_RST_ZOOM_HCTRL = 8'h20;
  localparam logic [7:0] STW_RST_GAIN_EXP_HIGH = 8'h00;
  localparam logic [7:0] STW_RST_FLEN_PAD_LOW = 8'h00;
  localparam logic [7:0] STW_RST_FLEN_PAD_HIGH = 8'h00;
  localparam logic [7:0] STW_RST_ZOOM_VST_LOW = 8'h00;
  localparam logic [7:0] STW_RST_ZOOM_VST_HIGH = 8'h00;
  localparam logic [7:0] STW_RST_FLASH_CTRL = 8'h20;
  localparam logic [7:0] STW_RST_BAND_STEP_HIGH = 8'h00;
  localparam logic [7:0] STW_RST_BAND_50_LOW = 8'hCA;
  localparam logic [7:0] STW_RST_BAND_60_LOW = 8'hA8;
  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int STW_PCLK_DIV_MSB = 7;
  localparam int STW_PCLK_DIV_LSB = 6;
  localparam int STW_HWIN_END_MSB = 5;
  localparam int STW_HWIN_END_LSB = 3;
  localparam int STW_HWIN_START_MSB = 2;
  localparam int STW_HWIN_START_LSB = 0;
  localparam int STW_ZOOM_HSTART_BIT = 2;
  localparam int STW_GAIN_HIGH_MSB = 7;
  localparam int STW_GAIN_HIGH_LSB = 6;
  localparam int STW_EXP_HIGH_MSB = 5;
  localparam int STW_EXP_HIGH_LSB = 0;
  localparam int STW_ZOOM_VST_LOW_MSB = 1;
  localparam int STW_ZOOM_VST_LOW_LSB = 0;
  localparam int STW_BAND_50_MSB = 7;
  localparam int STW_BAND_50_LSB = 6;
  localparam int STW_BAND_60_MSB = 5;
  localparam int STW_BAND_60_LSB = 4;
  localparam int STW_HSYNC_EXT_MSB = 3;
  localparam int STW_HSYNC_EXT_LSB = 2;
  ////////////////////////////////////////////////////////////////////////////
  // pixel clock divide codes and unit scales
  typedef enum logic [1:0] {
    STW_DIV_NONE_A = 2'h0,
    STW_DIV_NONE_B = 2'h1,
    STW_DIV_BY_2 = 2'h2,
    STW_DIV_BY_4 = 2'h3
  } stw_div_t;
  localparam int STW_PIX_PER_UNIT = 2;
  localparam int STW_LINES_PER_HIGH = 256;
endpackage
`default_nettype wire

/* verilog/stw_regs.sv */
// stw_regs: timing and window register group of the sensor control bank,
// with the bank select register and the derived timing values.
// assumes: a serial control front end hands over decoded byte accesses
// (address, data, one-cycle write and read strobes) on clk_i; the window
// high bytes and the sync extension bits arrive from other registers on clk_i.
`default_nettype none

// Behaviour
// - group answers only while bank select at 0xFF holds 01
// - sync end is 8 low bits plus 2 high bits, 2 pixels per unit
// - pixel clock divide bits 7:6: 00/01 none, 10 by two, 11 by four
// - bits 5:3 give three low bits of horizontal window end
// - bits 2:0 give three low bits of horizontal window start
// - bit 2 of zoom control is zoom horizontal start; rest reserved
// - extension bits 7:6 are gain 9:8, bits 5:0 exposure 15:10
// - each low pad count adds one line time to the frame
// - each high pad count adds 256 line times to the frame
// - zoom vertical start is 8 high bits above 2 low bits
// - flash control is a full 8-bit field
// - 50 Hz banding step is bits 7:6 high above 8-bit low register
// - 60 Hz banding step is bits 5:4 high above 8-bit low register
// - each unit of 11-bit window start and end is two pixels
// - sync extension bits 3:2 are the top bits of sync end
module stw_regs
  import stw_pkg::*;
#(
  parameter int FLEN_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // register access
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // parts held in other registers
  input wire logic [7:0] hwindow_start_high_i,
  input wire logic [7:0] hwindow_end_high_i,
  input wire logic [7:0] line_and_sync_extension_i,
  // derived timing values
  output logic [10:0] hsync_end_pix_o,
  output logic [11:0] hwindow_start_pix_o,
  output logic [11:0] hwindow_end_pix_o,
  output logic pclk_en_o,
  output logic zoom_hstart_o,
  output logic [1:0] gain_high_o,
  output logic [5:0] exposure_high_o,
  output logic [FLEN_W-1:0] frame_pad_lines_o,
  output logic [9:0] zoom_vstart_o,
  output logic [7:0] flash_ctrl_o,
  output logic [9:0] band_50_step_o,
  output logic [9:0] band_60_step_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pending-part tracking: set by a write wins over the clear on commit
  function automatic logic [1:0] pend_next(input logic [1:0] cur, input logic commit,
                                           input logic wr_lo, input logic wr_hi);
    logic [1:0] base;
    base = commit ? 2'h0 : cur;
    pend_next = base | {wr_hi, wr_lo};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic [7:0] bank_sel_q;
  logic bank_on;
  logic in_group;
  logic [7:0] rd_mux;

  logic [7:0] hsync_end_low_q;
  logic [7:0] pixel_clock_and_hwindow_low_q;
  logic [7:0] zoom_horizontal_control_q;
  logic [7:0] gain_exposure_high_bits_q;
  logic [7:0] frame_length_pad_low_q;
  logic [7:0] frame_length_pad_high_q;
  logic [7:0] zoom_vstart_low_q;
  logic [7:0] zoom_vstart_high_q;
  logic [7:0] flash_control_q;
  logic [7:0] banding_step_high_q;
  logic [7:0] banding_50hz_low_q;
  logic [7:0] banding_60hz_low_q;

  assign bank_on = (bank_sel_q == STW_BANK_DEVICE);

  always_comb begin
    in_group = 1'b1;
    rd_mux = 8'h00;
    case (reg_addr_i)
      STW_OFF_HSYNC_END_LOW: rd_mux = hsync_end_low_q;
      STW_OFF_PCLK_HWIN_LOW: rd_mux = pixel_clock_and_hwindow_low_q;
      STW_OFF_ZOOM_HCTRL: rd_mux = zoom_horizontal_control_q;
      STW_OFF_GAIN_EXP_HIGH: rd_mux = gain_exposure_high_bits_q;
      STW_OFF_FLEN_PAD_LOW: rd_mux = frame_length_pad_low_q;
      STW_OFF_FLEN_PAD_HIGH: rd_mux = frame_length_pad_high_q;
      STW_OFF_ZOOM_VST_LOW: rd_mux = zoom_vstart_low_q;
      STW_OFF_ZOOM_VST_HIGH: rd_mux = zoom_vstart_high_q;
      STW_OFF_FLASH_CTRL: rd_mux = flash_control_q;
      STW_OFF_BAND_STEP_HIGH: rd_mux = banding_step_high_q;
      STW_OFF_BAND_50_LOW: rd_mux = banding_50hz_low_q;
      STW_OFF_BAND_60_LOW: rd_mux = banding_60hz_low_q;
      default: in_group = 1'b0;
    endcase
  end

  logic wr_bank;
  logic wr_grp;
  assign wr_bank = reg_wr_i && (reg_addr_i == STW_OFF_BANK_SEL);
  assign wr_grp = reg_wr_i && bank_on && in_group;

  function automatic logic hit_wr(input logic grp, input logic [7:0] a, input logic [7:0] off);
    hit_wr = grp && (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bank select
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      bank_sel_q <= STW_RST_BANK_SEL;
    end else if (wr_bank) begin
      bank_sel_q <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hsync_end_low_q <= STW_RST_HSYNC_END_LOW;
      pixel_clock_and_hwindow_low_q <= STW_RST_PCLK_HWIN_LOW;
      zoom_horizontal_control_q <= STW_RST_ZOOM_HCTRL;
      gain_exposure_high_bits_q <= STW_RST_GAIN_EXP_HIGH;
      frame_length_pad_low_q <= STW_RST_FLEN_PAD_LOW;
      frame_length_pad_high_q <= STW_RST_FLEN_PAD_HIGH;
      zoom_vstart_low_q <= STW_RST_ZOOM_VST_LOW;
      zoom_vstart_high_q <= STW_RST_ZOOM_VST_HIGH;
      flash_control_q <= STW_RST_FLASH_CTRL;
      banding_step_high_q <= STW_RST_BAND_STEP_HIGH;
      banding_50hz_low_q <= STW_RST_BAND_50_LOW;
      banding_60hz_low_q <= STW_RST_BAND_60_LOW;
    end else if (wr_grp) begin
      case (reg_addr_i)
        STW_OFF_HSYNC_END_LOW: hsync_end_low_q <= reg_wdata_i;
        STW_OFF_PCLK_HWIN_LOW: pixel_clock_and_hwindow_low_q <= reg_wdata_i;
        STW_OFF_ZOOM_HCTRL: zoom_horizontal_control_q <= reg_wdata_i;
        STW_OFF_GAIN_EXP_HIGH: gain_exposure_high_bits_q <= reg_wdata_i;
        STW_OFF_FLEN_PAD_LOW: frame_length_pad_low_q <= reg_wdata_i;
        STW_OFF_FLEN_PAD_HIGH: frame_length_pad_high_q <= reg_wdata_i;
        STW_OFF_ZOOM_VST_LOW: zoom_vstart_low_q <= reg_wdata_i;
        STW_OFF_ZOOM_VST_HIGH: zoom_vstart_high_q <= reg_wdata_i;
        STW_OFF_FLASH_CTRL: flash_control_q <= reg_wdata_i;
        STW_OFF_BAND_STEP_HIGH: banding_step_high_q <= reg_wdata_i;
        STW_OFF_BAND_50_LOW: banding_50hz_low_q <= reg_wdata_i;
        STW_OFF_BAND_60_LOW: banding_60hz_low_q <= reg_wdata_i;
        default: hsync_end_low_q <= hsync_end_low_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read answer
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
      reg_hit_o <= 1'b0;
    end else if (reg_rd_i) begin
      if (reg_addr_i == STW_OFF_BANK_SEL) begin
        reg_rdata_o <= bank_sel_q;
        reg_hit_o <= 1'b1;
      end else begin
        reg_rdata_o <= (bank_on && in_group) ? rd_mux : 8'h00;
        reg_hit_o <= bank_on && in_group;
      end
    end else begin
      reg_hit_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // split fields inside the group: commit once both parts written
  logic [1:0] flen_pend_q;
  logic [1:0] zvst_pend_q;
  logic [1:0] band50_pend_q;
  logic [1:0] band60_pend_q;
  logic flen_commit;
  logic zvst_commit;
  logic band50_commit;
  logic band60_commit;
  logic wr_band_high;

  assign flen_commit = (flen_pend_q == 2'h3);
  assign zvst_commit = (zvst_pend_q == 2'h3);
  assign band50_commit = (band50_pend_q == 2'h3);
  assign band60_commit = (band60_pend_q == 2'h3);
  assign wr_band_high = hit_wr(wr_grp, reg_addr_i, STW_OFF_BAND_STEP_HIGH);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      flen_pend_q <= 2'h0;
      zvst_pend_q <= 2'h0;
      band50_pend_q <= 2'h0;
      band60_pend_q <= 2'h0;
    end else begin
      flen_pend_q <= pend_next(flen_pend_q, flen_commit, hit_wr(wr_grp, reg_addr_i, STW_OFF_FLEN_PAD_LOW),
                               hit_wr(wr_grp, reg_addr_i, STW_OFF_FLEN_PAD_HIGH));
      zvst_pend_q <= pend_next(zvst_pend_q, zvst_commit, hit_wr(wr_grp, reg_addr_i, STW_OFF_ZOOM_VST_LOW),
                               hit_wr(wr_grp, reg_addr_i, STW_OFF_ZOOM_VST_HIGH));
      band50_pend_q <= pend_next(band50_pend_q, band50_commit, hit_wr(wr_grp, reg_addr_i, STW_OFF_BAND_50_LOW),
                                 wr_band_high);
      band60_pend_q <= pend_next(band60_pend_q, band60_commit, hit_wr(wr_grp, reg_addr_i, STW_OFF_BAND_60_LOW),
                                 wr_band_high);
    end
  end

  logic [FLEN_W-1:0] flen_rst;
  logic [FLEN_W-1:0] flen_now;
  assign flen_rst = FLEN_W'({STW_RST_FLEN_PAD_HIGH, STW_RST_FLEN_PAD_LOW});
  assign flen_now = FLEN_W'(frame_length_pad_high_q) * FLEN_W'(STW_LINES_PER_HIGH)
                  + FLEN_W'(frame_length_pad_low_q);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      frame_pad_lines_o <= flen_rst;
    end else if (flen_commit) begin
      frame_pad_lines_o <= flen_now;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      zoom_vstart_o <= {STW_RST_ZOOM_VST_HIGH, STW_RST_ZOOM_VST_LOW[STW_ZOOM_VST_LOW_MSB:STW_ZOOM_VST_LOW_LSB]};
    end else if (zvst_commit) begin
      zoom_vstart_o <= {zoom_vstart_high_q,
                        zoom_vstart_low_q[STW_ZOOM_VST_LOW_MSB:STW_ZOOM_VST_LOW_LSB]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      band_50_step_o <= {STW_RST_BAND_STEP_HIGH[STW_BAND_50_MSB:STW_BAND_50_LSB], STW_RST_BAND_50_LOW};
    end else if (band50_commit) begin
      band_50_step_o <= {banding_step_high_q[STW_BAND_50_MSB:STW_BAND_50_LSB], banding_50hz_low_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      band_60_step_o <= {STW_RST_BAND_STEP_HIGH[STW_BAND_60_MSB:STW_BAND_60_LSB], STW_RST_BAND_60_LOW};
    end else if (band60_commit) begin
      band_60_step_o <= {banding_step_high_q[STW_BAND_60_MSB:STW_BAND_60_LSB], banding_60hz_low_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fields combined with parts held elsewhere
  logic [9:0] hsync_end_units;
  logic [10:0] hwin_start_units;
  logic [10:0] hwin_end_units;
  assign hsync_end_units = {line_and_sync_extension_i[STW_HSYNC_EXT_MSB:STW_HSYNC_EXT_LSB],
                            hsync_end_low_q};
  assign hwin_start_units = {hwindow_start_high_i,
                             pixel_clock_and_hwindow_low_q[STW_HWIN_START_MSB:STW_HWIN_START_LSB]};
  assign hwin_end_units = {hwindow_end_high_i,
                           pixel_clock_and_hwindow_low_q[STW_HWIN_END_MSB:STW_HWIN_END_LSB]};

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hsync_end_pix_o <= 11'h000;
      hwindow_start_pix_o <= 12'h000;
      hwindow_end_pix_o <= 12'h000;
    end else begin
      hsync_end_pix_o <= 11'(hsync_end_units) * 11'(STW_PIX_PER_UNIT);
      hwindow_start_pix_o <= 12'(hwin_start_units) * 12'(STW_PIX_PER_UNIT);
      hwindow_end_pix_o <= 12'(hwin_end_units) * 12'(STW_PIX_PER_UNIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single-bit and direct fields
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      zoom_hstart_o <= STW_RST_ZOOM_HCTRL[STW_ZOOM_HSTART_BIT];
      gain_high_o <= STW_RST_GAIN_EXP_HIGH[STW_GAIN_HIGH_MSB:STW_GAIN_HIGH_LSB];
      exposure_high_o <= STW_RST_GAIN_EXP_HIGH[STW_EXP_HIGH_MSB:STW_EXP_HIGH_LSB];
      flash_ctrl_o <= STW_RST_FLASH_CTRL;
    end else begin
      zoom_hstart_o <= zoom_horizontal_control_q[STW_ZOOM_HSTART_BIT];
      gain_high_o <= gain_exposure_high_bits_q[STW_GAIN_HIGH_MSB:STW_GAIN_HIGH_LSB];
      exposure_high_o <= gain_exposure_high_bits_q[STW_EXP_HIGH_MSB:STW_EXP_HIGH_LSB];
      flash_ctrl_o <= flash_control_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel clock divider: one enable pulse per output pixel clock
  stw_div_t div_code;
  logic [1:0] div_cnt_q;
  logic div_hit;
  assign div_code = stw_div_t'(pixel_clock_and_hwindow_low_q[STW_PCLK_DIV_MSB:STW_PCLK_DIV_LSB]);

  always_comb begin
    case (div_code)
      STW_DIV_BY_2: div_hit = (div_cnt_q[0] == 1'b1);
      STW_DIV_BY_4: div_hit = (div_cnt_q == 2'h3);
      default: div_hit = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      div_cnt_q <= 2'h0;
      pclk_en_o <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + 2'h1;
      pclk_en_o <= div_hit;
    end
  end

endmodule
`default_nettype wire

/* testbench/stw_regs_chk.sv */
// stw_regs_chk: timing checks on the ports of the register group.
// assumes: bound to stw_regs; one clock, synchronous active-low reset.
`default_nettype none
module stw_regs_chk
  import stw_pkg::*;
#(
  parameter int FLEN_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // register access
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_hit_o,
  // parts from other registers
  input wire logic [7:0] hwindow_start_high_i,
  input wire logic [7:0] hwindow_end_high_i,
  input wire logic [7:0] line_and_sync_extension_i,
  // derived values
  input wire logic [10:0] hsync_end_pix_o,
  input wire logic [11:0] hwindow_start_pix_o,
  input wire logic [11:0] hwindow_end_pix_o,
  input wire logic zoom_hstart_o,
  input wire logic [1:0] gain_high_o,
  input wire logic [5:0] exposure_high_o,
  input wire logic [FLEN_W-1:0] frame_pad_lines_o,
  input wire logic [7:0] flash_ctrl_o,
  input wire logic [9:0] band_50_step_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////////
  // copy of bank select
  logic [7:0] bank_q;
  logic bank_ok;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      bank_q <= STW_RST_BANK_SEL;
    end else if (reg_wr_i && reg_addr_i == STW_OFF_BANK_SEL) begin
      bank_q <= reg_wdata_i;
    end
  end
  assign bank_ok = bank_q == STW_BANK_DEVICE;
  sequence s_wr(logic [7:0] a);
    reg_wr_i && reg_addr_i == a && bank_ok;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // assertions
  bank_read_a: assert property (reg_rd_i && reg_addr_i == STW_OFF_BANK_SEL |=>
    reg_hit_o && reg_rdata_o == $past(bank_q)) else $error("bank select read wrong");
  hidden_read_a: assert property (reg_rd_i && reg_addr_i != STW_OFF_BANK_SEL &&
    (!bank_ok || reg_addr_i == 8'h33) |=> !reg_hit_o && reg_rdata_o == 8'h00) else $error("refused read answered");
  hidden_write_a: assert property (reg_wr_i && reg_addr_i == STW_OFF_FLASH_CTRL && !bank_ok |->
    ##2 $stable(flash_ctrl_o)) else $error("hidden write took effect");
  hsync_pos_a: assert property ($past(rst_b_i) |-> !hsync_end_pix_o[0] &&
    hsync_end_pix_o[10:9] == $past(line_and_sync_extension_i[3:2])) else $error("sync end top bits wrong");
  hwin_start_a: assert property ($past(rst_b_i) |-> !hwindow_start_pix_o[0] &&
    hwindow_start_pix_o[11:4] == $past(hwindow_start_high_i)) else $error("window start wrong");
  hwin_end_a: assert property ($past(rst_b_i) |-> !hwindow_end_pix_o[0] &&
    hwindow_end_pix_o[11:4] == $past(hwindow_end_high_i)) else $error("window end wrong");
  flash_out_a: assert property (s_wr(STW_OFF_FLASH_CTRL) |-> ##2 flash_ctrl_o == $past(reg_wdata_i, 2))
    else $error("flash control not applied");
  gain_exp_a: assert property (s_wr(STW_OFF_GAIN_EXP_HIGH) |->
    ##2 {gain_high_o, exposure_high_o} == $past(reg_wdata_i, 2)) else $error("gain or exposure bits wrong");
  zoom_hstart_a: assert property (s_wr(STW_OFF_ZOOM_HCTRL) |-> ##2 zoom_hstart_o == $past(reg_wdata_i[2], 2))
    else $error("zoom start bit wrong");
  pad_commit_a: assert property (s_wr(STW_OFF_FLEN_PAD_LOW) ##2 s_wr(STW_OFF_FLEN_PAD_HIGH) |->
    ##2 frame_pad_lines_o == FLEN_W'({$past(reg_wdata_i, 2), $past(reg_wdata_i, 4)})) else $error("frame pad wrong");
  band50_commit_a: assert property (s_wr(STW_OFF_BAND_STEP_HIGH) ##2 s_wr(STW_OFF_BAND_50_LOW) |->
    ##2 band_50_step_o == {$past(reg_wdata_i[7:6], 4), $past(reg_wdata_i, 2)}) else $error("band step wrong");
endmodule
bind stw_regs stw_regs_chk #(.FLEN_W(FLEN_W)) u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .hwindow_start_high_i(hwindow_start_high_i),
  .hwindow_end_high_i(hwindow_end_high_i), .line_and_sync_extension_i(line_and_sync_extension_i),
  .hsync_end_pix_o(hsync_end_pix_o), .hwindow_start_pix_o(hwindow_start_pix_o), .hwindow_end_pix_o(hwindow_end_pix_o),
  .zoom_hstart_o(zoom_hstart_o), .gain_high_o(gain_high_o), .exposure_high_o(exposure_high_o),
  .frame_pad_lines_o(frame_pad_lines_o), .flash_ctrl_o(flash_ctrl_o), .band_50_step_o(band_50_step_o));
`default_nettype wire

/* testbench/stw_host_model.sv */
// stw_host_model: host side of the decoded byte access port.
// assumes: driven by bench tasks; all changes come 1 ns after a rising edge.
`default_nettype none
module stw_host_model
  import stw_pkg::*;
(
  // clock
  input wire logic clk_i,
  // access port towards the device
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i,
  input wire logic hit_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one write, held until its taken edge; data inverted once released
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  // one read; answer taken in the cycle after the strobe edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
    h = hit_i;
  endtask
  // group is opened by selecting the device bank
  task automatic sel_bank(input logic [7:0] b);
    wr_reg(STW_OFF_BANK_SEL, b);
  endtask
endmodule
`default_nettype wire

/* testbench/stw_regs_tb_top.sv */
// stw_regs_tb_top: directed tests of the timing and window register group.
// assumes: stw_pkg, stw_regs, the checker and the host model compiled before.
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module stw_regs_tb_top
  import stw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr, wdata, rdata, rv;
  logic [7:0] hs_hi = 8'h00, he_hi = 8'h00, ext = 8'h00;
  logic wr, rd, hit, h_rd, pclk_en, zoom_hs;
  logic [10:0] hsync;
  logic [11:0] hs_pix, he_pix;
  logic [1:0] gain;
  logic [5:0] expo;
  logic [15:0] pad;
  logic [9:0] zoom_v, b50, b60;
  logic [7:0] flash;
  int bad_count = 0;
  int n_checks = 0;
  int cnt;
  localparam logic [7:0] OFFS [12] = '{STW_OFF_HSYNC_END_LOW, STW_OFF_PCLK_HWIN_LOW, STW_OFF_ZOOM_HCTRL,
    STW_OFF_GAIN_EXP_HIGH, STW_OFF_FLEN_PAD_LOW, STW_OFF_FLEN_PAD_HIGH, STW_OFF_ZOOM_VST_LOW, STW_OFF_ZOOM_VST_HIGH,
    STW_OFF_FLASH_CTRL, STW_OFF_BAND_STEP_HIGH, STW_OFF_BAND_50_LOW, STW_OFF_BAND_60_LOW};
  localparam logic [7:0] RSTS [12] = '{STW_RST_HSYNC_END_LOW, STW_RST_PCLK_HWIN_LOW, STW_RST_ZOOM_HCTRL,
    STW_RST_GAIN_EXP_HIGH, STW_RST_FLEN_PAD_LOW, STW_RST_FLEN_PAD_HIGH, STW_RST_ZOOM_VST_LOW, STW_RST_ZOOM_VST_HIGH,
    STW_RST_FLASH_CTRL, STW_RST_BAND_STEP_HIGH, STW_RST_BAND_50_LOW, STW_RST_BAND_60_LOW};
  always #50 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  // device and host
  stw_regs #(.FLEN_W(16)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .reg_hit_o(hit), .hwindow_start_high_i(hs_hi), .hwindow_end_high_i(he_hi),
    .line_and_sync_extension_i(ext), .hsync_end_pix_o(hsync), .hwindow_start_pix_o(hs_pix),
    .hwindow_end_pix_o(he_pix), .pclk_en_o(pclk_en), .zoom_hstart_o(zoom_hs), .gain_high_o(gain),
    .exposure_high_o(expo), .frame_pad_lines_o(pad), .zoom_vstart_o(zoom_v), .flash_ctrl_o(flash),
    .band_50_step_o(b50), .band_60_step_o(b60));
  stw_host_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata),
    .hit_i(hit));
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic eh);
    host.rd_reg(a, rv, h_rd);
    `CHK(rv, e)
    `CHK(h_rd, eh)
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    rd_chk(STW_OFF_FLASH_CTRL, 8'h00, 1'b0);
    rd_chk(STW_OFF_BANK_SEL, STW_RST_BANK_SEL, 1'b1);
    `CHK(flash, STW_RST_FLASH_CTRL)
    `CHK(b50, {STW_RST_BAND_STEP_HIGH[7:6], STW_RST_BAND_50_LOW})
    `CHK(b60, {STW_RST_BAND_STEP_HIGH[5:4], STW_RST_BAND_60_LOW})
    `CHK(pad, 16'h0000)
    host.sel_bank(STW_BANK_DEVICE);
    for (int i = 0; i < 12; i++) begin
      rd_chk(OFFS[i], RSTS[i], 1'b1);
    end
    rd_chk(8'h33, 8'h00, 1'b0);
    $display("test reset_values done");
    for (int i = 0; i < 12; i++) begin
      host.wr_reg(OFFS[i], OFFS[i] ^ 8'hA5);
    end
    for (int i = 0; i < 12; i++) begin
      rd_chk(OFFS[i], OFFS[i] ^ 8'hA5, 1'b1);
    end
    `CHK(flash, 8'hEE)
    `CHK({gain, expo}, 8'hE0)
    `CHK(pad, 16'hE2E3)
    `CHK(zoom_v, 10'h3B1)
    `CHK(b50, 10'h3EA)
    `CHK(b60, 10'h2F5)
    $display("test write_readback done");
    host.sel_bank(8'h00);
    host.wr_reg(STW_OFF_FLASH_CTRL, 8'h5A);
    rd_chk(STW_OFF_FLASH_CTRL, 8'h00, 1'b0);
    host.sel_bank(STW_BANK_DEVICE);
    rd_chk(STW_OFF_FLASH_CTRL, 8'hEE, 1'b1);
    host.wr_reg(STW_OFF_FLEN_PAD_HIGH, 8'h02);
    tick(4);
    `CHK(pad, 16'hE2E3)
    host.wr_reg(STW_OFF_FLEN_PAD_LOW, 8'hFF);
    tick(3);
    `CHK(pad, 16'h02FF)
    $display("test hidden_and_split done");
    host.wr_reg(STW_OFF_ZOOM_HCTRL, 8'h04);
    hs_hi = 8'hA5;
    he_hi = 8'h3C;
    ext = 8'h0C;
    tick(3);
    `CHK(zoom_hs, 1'b1)
    `CHK(hsync, 11'h728)
    `CHK(hs_pix, 12'hA5E)
    `CHK(he_pix, 12'h3C4)
    for (int c = 0; c < 4; c++) begin
      host.wr_reg(STW_OFF_PCLK_HWIN_LOW, {c[1:0], 6'h17});
      tick(4);
      cnt = 0;
      for (int k = 0; k < 16; k++) begin
        if (pclk_en === 1'b1) begin
          cnt++;
        end
        tick(1);
      end
      `CHK(cnt, (c < 2) ? 16 : (c == 2) ? 8 : 4)
    end
    $display("test timing_outputs done");
    stop_test();
  end
endmodule
`default_nettype wire
